// [include/lvd_pkg.sv]
package lvd_pkg;

    typedef enum logic {
        LVD_SEQ_IDLE = 1'b0,
        LVD_SEQ_ARMED = 1'b1
    } lvd_seq_t;

    typedef struct packed {
        logic [1:0] vsync;
        logic det_on;
        logic rst_mode;
        logic lvl_sel;
        logic ram_stat;
        lvd_seq_t seq;
        logic prot_err;
        logic low_flag;
        logic irq;
        logic lvi_rst;
        logic [15:0] settle_cnt;
        logic settled;
        logic [4:0] cause;
    } lvd_core_t;

    typedef struct packed {
        logic ack;
        logic [31:0] dat;
    } lvd_wb_t;

endpackage

// [include/lvd_reg_if.sv]
`timescale 1ns/1ps
`default_nettype none

interface lvd_reg_if;
    logic wr;
    logic [7:0] addr;
    logic [7:0] wdata;
    logic [31:0] rdata;

    modport bus (output wr, output addr, output wdata, input rdata);
    modport core (input wr, input addr, input wdata, output rdata);
endinterface

`default_nettype wire

// [include/lvd_regs.svh]
`ifndef LVD_REGS_SVH
`define LVD_REGS_SVH

// Register byte offsets.
`define LVD_AW 8
`define LVD_OFS_CTRL 8'h00
`define LVD_OFS_LEVEL 8'h04
`define LVD_OFS_RAM_DATA_STATUS 8'h08
`define LVD_OFS_PROT 8'h0c
`define LVD_OFS_STAT 8'h10
`define LVD_OFS_CAUSE 8'h14

// Field positions.
`define LVD_CTRL_ON_BIT 7
`define LVD_CTRL_MODE_BIT 1
`define LVD_CTRL_FLAG_BIT 0
`define LVD_LEVEL_SEL_BIT 0
`define LVD_RAM_DATA_STATUS_BIT 0
`define LVD_PROT_ARMED_BIT 0
`define LVD_PROT_ERR_BIT 1
`define LVD_STAT_LOCK_BIT 0
`define LVD_STAT_SETTLED_BIT 1
`define LVD_CAUSE_W 5

// Reset values.
`define LVD_RST_ON 1'b0
`define LVD_RST_MODE 1'b0
`define LVD_RST_LEVEL 1'b0
`define LVD_RST_RAM_DATA_STATUS 1'b0
`define LVD_RST_CAUSE 5'h00

// Key that arms the protected write sequence.
`define LVD_PROT_KEY 8'ha5

// Timing.
`define LVD_CLK_PERIOD_PS 5000
`define LVD_SETTLE_NS 200000
`define LVD_SETTLE_CYC ((`LVD_SETTLE_NS * 1000 + `LVD_CLK_PERIOD_PS - 1) / `LVD_CLK_PERIOD_PS)
`define LVD_CNT_W 16

`endif

// [verification/lvd_bench.sv]
`timescale 1ns/1ps
`default_nettype none

module lvd_bench;
    logic clk_in = 1'b0;
    logic rst_n_in = 1'b0;
    logic cyc = 1'b0;
    logic stb = 1'b0;
    logic we = 1'b0;
    logic vb = 1'b0;
    logic lvl;
    logic [3:0] sel = 4'hf;
    logic [3:0] rsrc = 4'h0;
    logic [7:0] adr = 8'h00;
    logic [31:0] dat = 32'h0;
    logic [31:0] rd;
    logic [31:0] r;
    logic [31:0] seed = 32'h3b4e;
    wire logic ack;
    wire logic irq;
    wire logic undervoltage_detection;
    wire logic ram_data_status;
    wire logic [31:0] rdat;
    int fail_count = 0;
    int checks = 0;
    int cycles = 0;
    int i;

    lvd_top #(.SETTLE_CYCLES(20)) u_lvd_top (
        .clk_in(clk_in), .rst_n_in(rst_n_in), .wb_cyc_in(cyc), .wb_stb_in(stb),
        .wb_we_in(we), .wb_sel_in(sel), .wb_adr_in(adr), .wb_dat_in(dat),
        .wb_ack_out(ack), .wb_dat_out(rdat), .voltage_below_in(vb),
        .wdt_reset_in(rsrc[0]), .clkmon_reset_in(rsrc[1]), .ram_access_reset_in(rsrc[2]),
        .other_reset_in(rsrc[3]), .voltage_low_irq_out(irq), .lvi_reset_req_out(undervoltage_detection),
        .ram_data_status_out(ram_data_status)
    );

    always #2.5 clk_in = ~clk_in;

    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction

    function automatic logic [31:0] ctrl_val(input logic on, input logic md, input logic fl);
        return {24'h0, on, 5'h0, md, fl};
    endfunction

    task automatic stop_test();
        $display("checks=%0d fail_count=%0d", checks, fail_count);
        if (fail_count == 0 && checks > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp) begin
            fail_count++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    // The request is held until ack is seen at an edge; no cycle count is assumed.
    task automatic wb(input logic w, input logic [7:0] a, input logic [7:0] d,
                      input logic [3:0] s, output logic [31:0] q);
        int n;
        n = 0;
        @(posedge clk_in);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        sel <= s;
        dat <= {24'h0, d};
        do begin
            @(posedge clk_in);
            n++;
        end while (ack !== 1'b1 && n < 50);
        q = rdat;
        cyc <= 1'b0;
        stb <= 1'b0;
        we <= 1'b0;
        if (n >= 50) begin
            fail_count++;
            stop_test();
        end
    endtask

    task automatic pulse(input int k);
        @(posedge clk_in);
        rsrc <= 4'h1 << k;
        @(posedge clk_in);
        rsrc <= 4'h0;
    endtask

    always @(posedge clk_in) begin
        cycles++;
        if (cycles == 5000) begin
            fail_count++;
            stop_test();
        end
    end

    initial begin
        repeat (3) @(posedge clk_in);
        rst_n_in <= 1'b1;
        wb(1'b0, 8'h00, 8'h00, 4'hf, rd);
        chk(rd, ctrl_val(1'b0, 1'b0, 1'b0));
        lvl = 1'b0;
        for (i = 0; i < 12; i++) begin
            r = rnd();
            wb(1'b1, 8'h04, {7'h0, r[8]}, r[3:0], rd);
            if (r[0]) begin
                lvl = r[8];
            end
            wb(1'b0, 8'h04, 8'h00, 4'hf, rd);
            chk(rd, {31'h0, lvl});
        end
        wb(1'b1, 8'h20, 8'hff, 4'hf, rd);
        wb(1'b0, 8'h20, 8'h00, 4'hf, rd);
        chk(rd, 32'h0);
        for (i = 0; i < 4; i++) begin
            if (i == 3) begin
                wb(1'b1, 8'h08, 8'h01, 4'hf, rd);
            end else begin
                pulse(i);
            end
            wb(1'b1, 8'h08, 8'h00, 4'hf, rd);
            repeat (2) @(posedge clk_in);
            chk({31'h0, ram_data_status}, 32'h1);
            wb(1'b0, 8'h0c, 8'h00, 4'hf, rd);
            chk(rd, 32'h2);
            wb(1'b1, 8'h0c, 8'ha5, 4'hf, rd);
            wb(1'b0, 8'h0c, 8'h00, 4'hf, rd);
            chk(rd, 32'h1);
            wb(1'b1, 8'h08, 8'h00, 4'hf, rd);
            repeat (2) @(posedge clk_in);
            chk({31'h0, ram_data_status}, 32'h0);
        end
        wb(1'b0, 8'h14, 8'h00, 4'hf, rd);
        chk(rd, 32'h7);
        wb(1'b1, 8'h14, 8'h07, 4'hf, rd);
        wb(1'b0, 8'h14, 8'h00, 4'hf, rd);
        chk(rd, 32'h0);
        wb(1'b1, 8'h04, 8'h01, 4'hf, rd);
        wb(1'b1, 8'h00, 8'h80, 4'hf, rd);
        // The settled bit still reads zero here; the flag is checked before it has been seen.
        wb(1'b0, 8'h10, 8'h00, 4'hf, rd);
        chk(rd, 32'h0);
        @(posedge clk_in);
        vb <= 1'b1;
        repeat (6) @(posedge clk_in);
        chk({30'h0, irq, undervoltage_detection}, 32'h2);
        chk({31'h0, ram_data_status}, 32'h1);
        repeat (20) @(posedge clk_in);
        wb(1'b0, 8'h10, 8'h00, 4'hf, rd);
        chk(rd, 32'h2);
        wb(1'b1, 8'h00, 8'h82, 4'hf, rd);
        repeat (3) @(posedge clk_in);
        chk({30'h0, irq, undervoltage_detection}, 32'h1);
        wb(1'b1, 8'h04, 8'h00, 4'hf, rd);
        wb(1'b0, 8'h04, 8'h00, 4'hf, rd);
        chk(rd, 32'h1);
        wb(1'b1, 8'h00, 8'h00, 4'hf, rd);
        wb(1'b0, 8'h00, 8'h00, 4'hf, rd);
        chk(rd, ctrl_val(1'b1, 1'b1, 1'b1));
        pulse(3);
        wb(1'b0, 8'h00, 8'h00, 4'hf, rd);
        chk(rd & 32'hfe, 32'h0);
        wb(1'b0, 8'h04, 8'h00, 4'hf, rd);
        chk(rd, 32'h0);
        wb(1'b0, 8'h14, 8'h00, 4'hf, rd);
        chk(rd, 32'h18);
        chk({31'h0, ram_data_status}, 32'h1);
        vb <= 1'b0;
        stop_test();
    end
endmodule

bind lvd_top lvd_monitor u_lvd_monitor (
    .clk_in(clk_in), .rst_n_in(rst_n_in), .wb_cyc_in(wb_cyc_in), .wb_stb_in(wb_stb_in),
    .wb_we_in(wb_we_in), .wb_sel_in(wb_sel_in), .wb_adr_in(wb_adr_in),
    .wb_dat_in(wb_dat_in), .wb_ack_out(wb_ack_out), .wb_dat_out(wb_dat_out),
    .voltage_below_in(voltage_below_in), .wdt_reset_in(wdt_reset_in),
    .clkmon_reset_in(clkmon_reset_in), .ram_access_reset_in(ram_access_reset_in),
    .other_reset_in(other_reset_in), .voltage_low_irq_out(voltage_low_irq_out),
    .lvi_reset_req_out(lvi_reset_req_out), .ram_data_status_out(ram_data_status_out)
);

`default_nettype wire

// [verification/lvd_monitor.sv]
`timescale 1ns/1ps
`default_nettype none

module lvd_monitor (
    // Clock and reset
    input wire logic clk_in,
    input wire logic rst_n_in,
    // Wishbone slave
    input wire logic wb_cyc_in,
    input wire logic wb_stb_in,
    input wire logic wb_we_in,
    input wire logic [3:0] wb_sel_in,
    input wire logic [7:0] wb_adr_in,
    input wire logic [31:0] wb_dat_in,
    input wire logic wb_ack_out,
    input wire logic [31:0] wb_dat_out,
    // Detector side
    input wire logic voltage_below_in,
    input wire logic wdt_reset_in,
    input wire logic clkmon_reset_in,
    input wire logic ram_access_reset_in,
    input wire logic other_reset_in,
    input wire logic voltage_low_irq_out,
    input wire logic lvi_reset_req_out,
    input wire logic ram_data_status_out
);
    default clocking @(posedge clk_in); endclocking
    default disable iff (!rst_n_in);

    wire logic req = wb_cyc_in & wb_stb_in;
    wire logic clr_req = req & wb_we_in & (wb_adr_in == 8'h08) & ~wb_dat_in[0];
    wire logic ram_src = wdt_reset_in | clkmon_reset_in | ram_access_reset_in;
    wire logic any_rst = ram_src | other_reset_in;

    a_ack_pulse: assert property (wb_ack_out |=> !wb_ack_out)
        else $error("ack held longer than one cycle");
    a_ack_answer: assert property (req && !wb_ack_out |=> wb_ack_out)
        else $error("request not answered in one cycle");
    a_ack_cause: assert property (wb_ack_out |-> $past(req))
        else $error("ack without a request");
    a_write_zero: assert property (wb_ack_out && $past(wb_we_in) |-> wb_dat_out == 32'h0)
        else $error("write answer carries data");
    a_irq_excl: assert property (!(voltage_low_irq_out && lvi_reset_req_out))
        else $error("interrupt and reset request together");
    a_irq_source: assert property (voltage_low_irq_out |-> $past(voltage_below_in, 4))
        else $error("interrupt without a synchronised low voltage");
    a_lvi_source: assert property (lvi_reset_req_out |-> $past(voltage_below_in, 4))
        else $error("reset request without a synchronised low voltage");
    a_ram_set: assert property (ram_src |-> ##[1:2] ram_data_status_out)
        else $error("reset source did not set ram status");
    a_ram_clear: assert property ($fell(ram_data_status_out) |->
        $past(clr_req, 1) || $past(clr_req, 2) || $past(clr_req, 3))
        else $error("ram status cleared without a write of zero");
    a_lock_hold: assert property (lvi_reset_req_out |=> !voltage_low_irq_out)
        else $error("reset mode left while locked");
    a_lock_release: assert property (any_rst |-> ##[1:2] !lvi_reset_req_out)
        else $error("reset source did not release the lock");
endmodule

`default_nettype wire

// [verilog/lvd_top.sv]
// Function
// - With detector on and reset mode set, level-select writes are ignored.
// - Set RAM status on undervoltage, instruction, watchdog, clock monitor, RAM-access reset.
// - RAM status clears only by writing zero through the protected sequence.
// - Reset mode set freezes control and level-select until non-undervoltage reset.
// - Interrupt follows low flag while detector on and reset mode clear.
`timescale 1ns/1ps
`default_nettype none
`include "lvd_regs.svh"

module lvd_top
    import lvd_pkg::*;
#(
    parameter int SETTLE_CYCLES = `LVD_SETTLE_CYC
) (
    // Clock and reset
    input wire logic clk_in,
    input wire logic rst_n_in,
    // Wishbone slave
    input wire logic wb_cyc_in,
    input wire logic wb_stb_in,
    input wire logic wb_we_in,
    input wire logic [3:0] wb_sel_in,
    input wire logic [7:0] wb_adr_in,
    input wire logic [31:0] wb_dat_in,
    output logic wb_ack_out,
    output logic [31:0] wb_dat_out,
    // Analog comparator, asynchronous to the clock
    input wire logic voltage_below_in,
    // Reset sources from the reset controller, one-cycle pulses on clk_in
    input wire logic wdt_reset_in,
    input wire logic clkmon_reset_in,
    input wire logic ram_access_reset_in,
    input wire logic other_reset_in,
    // Detector outputs
    output logic voltage_low_irq_out,
    output logic lvi_reset_req_out,
    output logic ram_data_status_out
);

    localparam logic [15:0] SETTLE_MAX = SETTLE_CYCLES[15:0];

    lvd_core_t c_q;
    lvd_core_t c_d;
    lvd_reg_if rif ();

    logic nonlvi_reset;
    logic wr_ctrl;
    logic wr_level;
    logic wr_ram_data_status;
    logic wr_prot;
    logic wr_cause;
    logic [4:0] cause_set;
    logic [31:0] rdata;

    lvd_wb_slave u_lvd_wb_slave (
        .clk_in(clk_in),
        .rst_n_in(rst_n_in),
        .wb_cyc_in(wb_cyc_in),
        .wb_stb_in(wb_stb_in),
        .wb_we_in(wb_we_in),
        .wb_sel_in(wb_sel_in),
        .wb_adr_in(wb_adr_in),
        .wb_dat_in(wb_dat_in),
        .wb_ack_out(wb_ack_out),
        .wb_dat_out(wb_dat_out),
        .rif(rif.bus)
    );

    assign nonlvi_reset = wdt_reset_in | clkmon_reset_in | ram_access_reset_in | other_reset_in;
    assign wr_ctrl = rif.wr && (rif.addr == `LVD_OFS_CTRL);
    assign wr_level = rif.wr && (rif.addr == `LVD_OFS_LEVEL);
    assign wr_ram_data_status = rif.wr && (rif.addr == `LVD_OFS_RAM_DATA_STATUS);
    assign wr_prot = rif.wr && (rif.addr == `LVD_OFS_PROT);
    assign wr_cause = rif.wr && (rif.addr == `LVD_OFS_CAUSE);
    assign cause_set = {c_q.lvi_rst, other_reset_in, ram_access_reset_in,
                        clkmon_reset_in, wdt_reset_in};

    // Read mux; unmapped offsets read as zero.
    always_comb begin
        rdata = 32'h0000_0000;
        case (rif.addr)
            `LVD_OFS_CTRL: begin
                rdata[`LVD_CTRL_ON_BIT] = c_q.det_on;
                rdata[`LVD_CTRL_MODE_BIT] = c_q.rst_mode;
                rdata[`LVD_CTRL_FLAG_BIT] = c_q.low_flag;
            end
            `LVD_OFS_LEVEL: begin
                rdata[`LVD_LEVEL_SEL_BIT] = c_q.lvl_sel;
            end
            `LVD_OFS_RAM_DATA_STATUS: begin
                rdata[`LVD_RAM_DATA_STATUS_BIT] = c_q.ram_stat;
            end
            `LVD_OFS_PROT: begin
                rdata[`LVD_PROT_ARMED_BIT] = (c_q.seq == LVD_SEQ_ARMED);
                rdata[`LVD_PROT_ERR_BIT] = c_q.prot_err;
            end
            `LVD_OFS_STAT: begin
                rdata[`LVD_STAT_LOCK_BIT] = c_q.rst_mode;
                rdata[`LVD_STAT_SETTLED_BIT] = c_q.settled;
            end
            `LVD_OFS_CAUSE: begin
                rdata[`LVD_CAUSE_W-1:0] = c_q.cause;
            end
            default: begin
                rdata = 32'h0000_0000;
            end
        endcase
    end
    assign rif.rdata = rdata;

    always_comb begin
        c_d = c_q;

        // The first stage feeds only the second; logic reads the second.
        c_d.vsync = {c_q.vsync[0], voltage_below_in};
        c_d.low_flag = c_q.vsync[1] & c_q.det_on;

        // Software wait after enabling; exposed so firmware can poll it.
        if (!c_q.det_on) begin
            c_d.settle_cnt = 16'h0000;
            c_d.settled = 1'b0;
        end else if (c_q.settle_cnt != SETTLE_MAX) begin
            c_d.settle_cnt = c_q.settle_cnt + 16'h0001;
        end else begin
            c_d.settled = 1'b1;
        end

        // Once reset mode is set both registers freeze, which also covers the
        // level-select lock with the detector on.
        if (wr_ctrl && !c_q.rst_mode) begin
            c_d.det_on = rif.wdata[`LVD_CTRL_ON_BIT];
            c_d.rst_mode = rif.wdata[`LVD_CTRL_MODE_BIT];
        end
        if (wr_level && !c_q.rst_mode) begin
            // Only bit zero is stored; the upper bits must be written as zero.
            c_d.lvl_sel = rif.wdata[`LVD_LEVEL_SEL_BIT];
        end

        // Protected sequence: key write arms, the next write is the one chance.
        case (c_q.seq)
            LVD_SEQ_IDLE: begin
                if (wr_prot && rif.wdata == `LVD_PROT_KEY) begin
                    c_d.seq = LVD_SEQ_ARMED;
                    c_d.prot_err = 1'b0;
                end
                if (wr_ram_data_status && !rif.wdata[`LVD_RAM_DATA_STATUS_BIT]) begin
                    c_d.prot_err = 1'b1;
                end
            end
            LVD_SEQ_ARMED: begin
                if (rif.wr) begin
                    c_d.seq = LVD_SEQ_IDLE;
                    if (wr_ram_data_status && !rif.wdata[`LVD_RAM_DATA_STATUS_BIT]) begin
                        c_d.ram_stat = 1'b0;
                    end else if (!wr_ram_data_status) begin
                        c_d.prot_err = 1'b1;
                    end
                end
            end
            default: begin
                c_d.seq = LVD_SEQ_IDLE;
            end
        endcase

        // Setting sources come after the clear so that a set wins.
        if (wr_ram_data_status && rif.wdata[`LVD_RAM_DATA_STATUS_BIT]) begin
            c_d.ram_stat = 1'b1;
        end
        if (c_q.low_flag || wdt_reset_in || clkmon_reset_in || ram_access_reset_in) begin
            c_d.ram_stat = 1'b1;
        end

        // Reset causes are write-one-to-clear, with a new cause winning.
        if (wr_cause) begin
            c_d.cause = c_q.cause & ~rif.wdata[`LVD_CAUSE_W-1:0];
        end
        c_d.cause = c_d.cause | cause_set;

        // Any reset other than undervoltage releases the lock and restores
        // the control and level-select values; RAM status survives it.
        if (nonlvi_reset) begin
            c_d.det_on = `LVD_RST_ON;
            c_d.rst_mode = `LVD_RST_MODE;
            c_d.lvl_sel = `LVD_RST_LEVEL;
            c_d.seq = LVD_SEQ_IDLE;
        end

        // Interrupt mode versus reset mode share the same flag.
        c_d.irq = c_q.low_flag & c_q.det_on & ~c_q.rst_mode;
        c_d.lvi_rst = c_q.low_flag & c_q.det_on & c_q.rst_mode;
    end

    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            c_q <= '0;
        end else begin
            c_q <= c_d;
        end
    end

    assign voltage_low_irq_out = c_q.irq;
    assign lvi_reset_req_out = c_q.lvi_rst;
    assign ram_data_status_out = c_q.ram_stat;

endmodule

`default_nettype wire

// [verilog/lvd_wb_slave.sv]
`timescale 1ns/1ps
`default_nettype none

module lvd_wb_slave
    import lvd_pkg::*;
(
    // Clock and reset
    input wire logic clk_in,
    input wire logic rst_n_in,
    // Wishbone slave
    input wire logic wb_cyc_in,
    input wire logic wb_stb_in,
    input wire logic wb_we_in,
    input wire logic [3:0] wb_sel_in,
    input wire logic [7:0] wb_adr_in,
    input wire logic [31:0] wb_dat_in,
    output logic wb_ack_out,
    output logic [31:0] wb_dat_out,
    // Register side
    lvd_reg_if.bus rif
);

    lvd_wb_t s_q;
    lvd_wb_t s_d;
    logic req;

    // A new request is one not yet answered; ack stands for exactly one cycle.
    assign req = wb_cyc_in & wb_stb_in & ~s_q.ack;
    assign rif.wr = req & wb_we_in & wb_sel_in[0];
    assign rif.addr = wb_adr_in;
    assign rif.wdata = wb_dat_in[7:0];

    always_comb begin
        s_d = s_q;
        s_d.ack = req;
        if (req) begin
            s_d.dat = wb_we_in ? 32'h0000_0000 : rif.rdata;
        end
    end

    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    assign wb_ack_out = s_q.ack;
    assign wb_dat_out = s_q.dat;

endmodule

`default_nettype wire
